// ### design/baud_prescaler.sv
`default_nettype none

// ------------------------------------------------------------------
// baud generator source prescaler: one-cycle tick at the chosen rate
// ------------------------------------------------------------------
module baud_prescaler (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // selection
  input wire logic [1:0] srcSel,
  input wire logic cardMode,
  // output enable pulse
  output logic tick
);

  logic [5:0] count_q; // division counter
  logic [5:0] count_d;
  logic [5:0] lastValue; // terminal count for the selected rate
  logic atLast;

  // map the two-bit source select to a terminal count
  function automatic logic [5:0] last_of(input logic [1:0] sel, input logic card);
    logic [5:0] v;
    v = serial_ctrl_pkg::DIV_1_LAST;
    case (sel)
      2'h0: v = serial_ctrl_pkg::DIV_1_LAST;
      2'h1: v = serial_ctrl_pkg::DIV_4_LAST;
      2'h2: v = serial_ctrl_pkg::DIV_16_LAST; // RULE_01
      2'h3: v = serial_ctrl_pkg::DIV_64_LAST; // RULE_01
      default: v = serial_ctrl_pkg::DIV_1_LAST;
    endcase
    // card mode only defines the two slow rates; the fast codes keep /1 and /4
    if (card && sel[1] == 1'b0) begin
      v = sel[0] ? serial_ctrl_pkg::DIV_4_LAST : serial_ctrl_pkg::DIV_1_LAST;
    end
    return v;
  endfunction

  assign lastValue = last_of(srcSel, cardMode);
  assign atLast = (count_q >= lastValue);
  assign count_d = atLast ? 6'h00 : count_q + 6'h01;
  assign tick = atLast;

  // counter, restarts when the rate shrinks below it
  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= 6'h00;
    end else begin
      count_q <= count_d;
    end
  end

endmodule // baud_prescaler

`default_nettype wire

// ### design/serial_control_enables.sv
`default_nettype none

module serial_control_enables (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // shift engine side
  input wire serial_ctrl_pkg::engine_stat_type engStat,
  output serial_ctrl_pkg::engine_ctrl_type engCtrl,
  output logic baudTick,
  // clock pin
  input wire logic clkPinIn,
  output logic clkPinOut,
  output logic clkPinOe,
  output logic clkPinSync,
  // interrupt requests
  output serial_ctrl_pkg::irq_req_type irqReq,
  output logic eventIrq
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] control_q; // serial_control_word
  logic [7:0] control_d;
  logic [7:0] mode_q; // mode_word
  logic [7:0] card_q; // card_mode_word
  logic rxFull_q; // rx_full_flag
  logic rxFull_d;
  logic overrun_q; // overrun_flag
  logic overrun_d;
  logic framing_q; // framing_flag
  logic framing_d;
  logic [serial_ctrl_pkg::EVT_WIDTH-1:0] event_q; // sticky events
  logic [serial_ctrl_pkg::EVT_WIDTH-1:0] event_d;
  logic [serial_ctrl_pkg::EVT_WIDTH-1:0] mask_q; // event mask
  logic [7:0] rdData_q; // read data, one cycle after the strobe
  logic [7:0] rdData_d;
  logic pinMeta_q; // first synchroniser stage
  logic pinSync_q; // second synchroniser stage

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  logic txIrqOn; // tx_irq_on
  logic rxIrqOn; // rx_irq_on
  logic txOn; // tx_on
  logic rxOn; // rx_on
  logic addrWaitOn; // addr_wait_on
  logic txDoneIrqOn; // tx_done_irq_on
  logic [1:0] clkSrcSel; // clk_src_sel_hi / clk_src_sel_lo
  logic syncMode; // clocked synchronous operation
  logic addrModeOn; // addr_mode_on
  logic [1:0] baudSrcSel; // baud_src_sel_hi / baud_src_sel_lo
  logic cardModeOn; // card_mode_on

  assign txIrqOn = control_q[serial_ctrl_pkg::POS_TX_IRQ_ON];
  assign rxIrqOn = control_q[serial_ctrl_pkg::POS_RX_IRQ_ON];
  assign txOn = control_q[serial_ctrl_pkg::POS_TX_ON];
  assign rxOn = control_q[serial_ctrl_pkg::POS_RX_ON];
  assign addrWaitOn = control_q[serial_ctrl_pkg::POS_ADDR_WAIT_ON];
  assign txDoneIrqOn = control_q[serial_ctrl_pkg::POS_TX_DONE_IRQ_ON];
  assign clkSrcSel = {control_q[serial_ctrl_pkg::POS_CLK_SRC_HI], control_q[serial_ctrl_pkg::POS_CLK_SRC_LO]};
  assign syncMode = mode_q[serial_ctrl_pkg::POS_SYNC_MODE];
  assign addrModeOn = mode_q[serial_ctrl_pkg::POS_ADDR_MODE_ON];
  assign baudSrcSel = {mode_q[serial_ctrl_pkg::POS_BAUD_SRC_HI], mode_q[serial_ctrl_pkg::POS_BAUD_SRC_LO]};
  assign cardModeOn = card_q[serial_ctrl_pkg::POS_CARD_MODE_ON];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wrControl;
  logic wrMode;
  logic wrFlags;
  logic wrEvent;
  logic wrMask;
  logic wrCard;

  assign wrControl = regWrite && (regAddr == serial_ctrl_pkg::OFS_CONTROL);
  assign wrMode = regWrite && (regAddr == serial_ctrl_pkg::OFS_MODE);
  assign wrFlags = regWrite && (regAddr == serial_ctrl_pkg::OFS_FLAGS);
  assign wrEvent = regWrite && (regAddr == serial_ctrl_pkg::OFS_EVENT);
  assign wrMask = regWrite && (regAddr == serial_ctrl_pkg::OFS_MASK);
  assign wrCard = regWrite && (regAddr == serial_ctrl_pkg::OFS_CARD);

  // ----------------------------------------------------------------
  // receive frame handling
  // ----------------------------------------------------------------
  logic waitActive; // address wait really in force
  logic frameSeen; // frame completed while the receiver is on
  logic frameSkip; // data frame dropped during address wait
  logic frameAccept; // frame stored with normal flag setting
  logic addrHit; // address frame ends the wait

  // address wait counts only in asynchronous address format
  assign waitActive = addrWaitOn && addrModeOn && !syncMode; // RULE_06
  // frames are only taken while reception is enabled
  assign frameSeen = engStat.rxFrameDone && rxOn; // RULE_05
  // data frames are skipped and touch no flag
  assign frameSkip = frameSeen && waitActive && !engStat.rxAddrBit; // RULE_07
  assign addrHit = frameSeen && waitActive && engStat.rxAddrBit; // RULE_08
  assign frameAccept = frameSeen && !frameSkip;

  // ----------------------------------------------------------------
  // control word next value
  // ----------------------------------------------------------------
  // the address frame clears the wait bit even if a write lands together
  always_comb begin
    control_d = control_q;
    if (wrControl) begin
      control_d = regWrData;
    end
    if (addrHit) begin
      control_d[serial_ctrl_pkg::POS_ADDR_WAIT_ON] = 1'b0; // RULE_08
    end
  end

  // ----------------------------------------------------------------
  // receive flags: set wins over a write-one clear
  // ----------------------------------------------------------------
  logic overrunHit; // frame arrives while the previous is unread

  assign overrunHit = frameAccept && rxFull_q;

  always_comb begin
    rxFull_d = rxFull_q;
    overrun_d = overrun_q;
    framing_d = framing_q;
    // software clears by writing ones
    if (wrFlags) begin
      rxFull_d = rxFull_q && !regWrData[serial_ctrl_pkg::POS_RX_FULL];
      overrun_d = overrun_q && !regWrData[serial_ctrl_pkg::POS_OVERRUN];
      framing_d = framing_q && !regWrData[serial_ctrl_pkg::POS_FRAMING];
    end
    // hardware set from accepted frames only
    if (frameAccept && !overrunHit && !engStat.rxFrameErr) begin
      rxFull_d = 1'b1; // RULE_07
    end
    if (overrunHit) begin
      overrun_d = 1'b1; // RULE_07
    end
    if (frameAccept && engStat.rxFrameErr) begin
      framing_d = 1'b1; // RULE_07
    end
  end

  // ----------------------------------------------------------------
  // sticky events and mask
  // ----------------------------------------------------------------
  logic lateWrite; // control write while a transfer runs
  logic [serial_ctrl_pkg::EVT_WIDTH-1:0] eventSet;

  // software must keep off the control word while busy; flag it if not
  assign lateWrite = wrControl && (engStat.txBusy || engStat.rxBusy); // RULE_11
  assign eventSet = {lateWrite, addrHit, frameSkip, frameAccept};

  // write one to clear, a new event in the same cycle survives
  always_comb begin
    event_d = event_q;
    if (wrEvent) begin
      event_d = event_q & ~regWrData[serial_ctrl_pkg::EVT_WIDTH-1:0];
    end
    event_d = event_d | eventSet;
  end

  assign eventIrq = |(event_q & mask_q);

  // ----------------------------------------------------------------
  // read multiplexer, no read alters any state
  // ----------------------------------------------------------------
  logic [7:0] flagView;

  assign flagView = {1'b0, rxFull_q, overrun_q, framing_q, 4'h0};

  always_comb begin
    rdData_d = 8'h00;
    if (regRead) begin
      case (regAddr)
        serial_ctrl_pkg::OFS_CONTROL: rdData_d = control_q; // RULE_10
        serial_ctrl_pkg::OFS_MODE: rdData_d = mode_q;
        serial_ctrl_pkg::OFS_FLAGS: rdData_d = flagView;
        serial_ctrl_pkg::OFS_EVENT: rdData_d = {4'h0, event_q};
        serial_ctrl_pkg::OFS_MASK: rdData_d = {4'h0, mask_q};
        serial_ctrl_pkg::OFS_CARD: rdData_d = card_q;
        default: rdData_d = 8'h00;
      endcase
    end
  end

  assign regRdData = rdData_q;

  // ----------------------------------------------------------------
  // register process
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      control_q <= serial_ctrl_pkg::RST_CONTROL;
      mode_q <= serial_ctrl_pkg::RST_MODE;
      card_q <= serial_ctrl_pkg::RST_CARD;
      rxFull_q <= 1'b0;
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
      event_q <= serial_ctrl_pkg::RST_EVENT;
      mask_q <= serial_ctrl_pkg::RST_EVENT;
      rdData_q <= 8'h00;
    end else begin
      control_q <= control_d;
      if (wrMode) begin
        mode_q <= regWrData;
      end
      if (wrCard) begin
        card_q <= {7'h00, regWrData[serial_ctrl_pkg::POS_CARD_MODE_ON]};
      end
      if (wrMask) begin
        mask_q <= regWrData[serial_ctrl_pkg::EVT_WIDTH-1:0];
      end
      rxFull_q <= rxFull_d;
      overrun_q <= overrun_d;
      framing_q <= framing_d;
      event_q <= event_d;
      rdData_q <= rdData_d;
    end
  end

  // ----------------------------------------------------------------
  // clock pin: two-stage synchroniser on the input
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
    end else begin
      pinMeta_q <= clkPinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  assign clkPinSync = pinSync_q;

  // async: 00 port, 01 bit-rate clock out, 1x external 16x in
  // sync: 0x clock out, 1x clock in
  logic pinDrives; // internal clock driven onto the pin
  logic extClk; // engine uses the pin as its clock

  assign extClk = clkSrcSel[1]; // RULE_12
  assign pinDrives = syncMode ? !clkSrcSel[1] : (clkSrcSel == 2'h1); // RULE_12
  assign clkPinOe = pinDrives;
  assign clkPinOut = pinDrives && engStat.bitClk;

  // ----------------------------------------------------------------
  // baud generator source
  // ----------------------------------------------------------------
  baud_prescaler baud_prescaler_i (
    .clock(clock),
    .reset(reset),
    .srcSel(baudSrcSel),
    .cardMode(cardModeOn),
    .tick(baudTick)
  );

  // ----------------------------------------------------------------
  // engine controls
  // ----------------------------------------------------------------
  assign engCtrl.txOn = txOn; // RULE_04
  assign engCtrl.rxOn = rxOn; // RULE_05
  assign engCtrl.extClkSel = extClk;
  assign engCtrl.rxStore = frameAccept;

  // ----------------------------------------------------------------
  // interrupt requests, each a plain AND of condition and enable
  // ----------------------------------------------------------------
  assign irqReq.txEmptyIrq = engStat.txEmpty && txIrqOn; // RULE_02 RULE_13
  assign irqReq.rxFullIrq = rxFull_q && rxIrqOn; // RULE_03 RULE_13
  assign irqReq.rxFaultIrq = (framing_q || overrun_q) && rxIrqOn; // RULE_03 RULE_13
  assign irqReq.txDoneIrq = engStat.txDone && txDoneIrqOn; // RULE_09 RULE_13

endmodule // serial_control_enables

`default_nettype wire

// ### design/serial_ctrl_pkg.sv
// How it works
// RULE_01 - card mode: source 10 is /16, 11 is /64
// RULE_02 - tx empty request passes only with bit 7
// RULE_03 - bit 6 gates rx full and rx fault
// RULE_04 - bit 5 enables the transmitter
// RULE_05 - bit 4 enables the receiver
// RULE_06 - address wait acts only in async address format
// RULE_07 - address wait skips data frames, no flags
// RULE_08 - address frame clears address wait by hardware
// RULE_09 - tx done request passes only with bit 2
// RULE_10 - control word readable anytime, no side effects
// RULE_11 - software writes control word only when idle
// RULE_12 - async clock pin: 00 port, 01 out, 1x in
// RULE_13 - each request is status AND enable, combinationally
`default_nettype none

package serial_ctrl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_CONTROL = 3'h0; // serial_control_word
  localparam logic [2:0] OFS_MODE = 3'h1; // mode_word
  localparam logic [2:0] OFS_FLAGS = 3'h2; // flag_word
  localparam logic [2:0] OFS_EVENT = 3'h3; // sticky event status
  localparam logic [2:0] OFS_MASK = 3'h4; // event mask
  localparam logic [2:0] OFS_CARD = 3'h5; // card_mode_word

  // ----------------------------------------------------------------
  // control word field positions
  // ----------------------------------------------------------------
  localparam int POS_TX_IRQ_ON = 7;
  localparam int POS_RX_IRQ_ON = 6;
  localparam int POS_TX_ON = 5;
  localparam int POS_RX_ON = 4;
  localparam int POS_ADDR_WAIT_ON = 3;
  localparam int POS_TX_DONE_IRQ_ON = 2;
  localparam int POS_CLK_SRC_HI = 1;
  localparam int POS_CLK_SRC_LO = 0;

  // mode word fields
  localparam int POS_SYNC_MODE = 7;
  localparam int POS_ADDR_MODE_ON = 2;
  localparam int POS_BAUD_SRC_HI = 1;
  localparam int POS_BAUD_SRC_LO = 0;

  // card mode word field
  localparam int POS_CARD_MODE_ON = 0;

  // flag word fields
  localparam int POS_RX_FULL = 6;
  localparam int POS_OVERRUN = 5;
  localparam int POS_FRAMING = 4;

  // event status / mask fields
  localparam int EVT_ACCEPT = 0;
  localparam int EVT_SKIP = 1;
  localparam int EVT_ADDR_HIT = 2;
  localparam int EVT_LATE_WRITE = 3;
  localparam int EVT_WIDTH = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CARD = 8'h00;
  localparam logic [EVT_WIDTH-1:0] RST_EVENT = 4'h0;

  // ----------------------------------------------------------------
  // prescaler divisions (counter terminal values)
  // ----------------------------------------------------------------
  localparam logic [5:0] DIV_1_LAST = 6'h00;
  localparam logic [5:0] DIV_4_LAST = 6'h03;
  localparam logic [5:0] DIV_16_LAST = 6'h0F;
  localparam logic [5:0] DIV_64_LAST = 6'h3F;

  // ----------------------------------------------------------------
  // carriers between this block and the shift engines, and its interrupt requests
  // ----------------------------------------------------------------
  typedef struct packed {
    logic txEmpty; // transmit data register empty (level)
    logic txDone; // transmit end (level)
    logic txBusy; // transmitter shifting
    logic rxBusy; // receiver shifting
    logic rxFrameDone; // one-cycle pulse: frame received
    logic rxAddrBit; // multiprocessor bit of that frame
    logic rxFrameErr; // stop bit error of that frame
    logic bitClk; // bit-rate clock level from the divider
  } engine_stat_type;

  typedef struct packed {
    logic txOn; // transmitter enabled
    logic rxOn; // receiver enabled
    logic extClkSel; // engine takes its clock from the pin
    logic rxStore; // one-cycle pulse: frame accepted into data reg
  } engine_ctrl_type;

  typedef struct packed {
    logic txEmptyIrq;
    logic rxFullIrq;
    logic rxFaultIrq;
    logic txDoneIrq;
  } irq_req_type;

endpackage : serial_ctrl_pkg

`default_nettype wire

// ### sim/engine_model.sv
`default_nettype none

// ------------------------------------------------------------------
// shift engine stand-in: levels, frame pulses, free bit clock
// ------------------------------------------------------------------
module engine_model (
  // clock
  input wire logic clock,
  // status towards the block
  output serial_ctrl_pkg::engine_stat_type engStat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_q; // bit clock divider
  initial engStat = '0;
  initial phase_q = 3'h0;
  // free bit clock; frame fields turn to garbage once the pulse is over
  always @(posedge clock) begin
    phase_q <= phase_q + 3'h1;
    engStat.bitClk <= phase_q[2];
    if (engStat.rxFrameDone) begin
      engStat.rxFrameDone <= 1'b0;
      engStat.rxAddrBit <= ~engStat.rxAddrBit;
      engStat.rxFrameErr <= ~engStat.rxFrameErr;
    end
  end
  // one received frame, promptly or after a stall
  task automatic frame(input logic addrBit, input logic err, input logic slow);
    repeat (slow ? 20 : 0) @(posedge clock);
    @(posedge clock);
    engStat.rxFrameDone <= 1'b1;
    engStat.rxAddrBit <= addrBit;
    engStat.rxFrameErr <= err;
    @(posedge clock);
  endtask
  // engine levels: tx empty, tx done, tx busy, rx busy
  task automatic levels(input logic [3:0] lv);
    @(posedge clock);
    {engStat.txEmpty, engStat.txDone, engStat.txBusy, engStat.rxBusy} <= lv;
  endtask
endmodule // engine_model

`default_nettype wire

// ### sim/serial_control_enables_asserts.sv
`default_nettype none

// ------------------------------------------------------------------
// port-level checker for the serial control block
// ------------------------------------------------------------------
module serial_control_enables_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // shift engine side
  input wire serial_ctrl_pkg::engine_stat_type engStat,
  input wire serial_ctrl_pkg::engine_ctrl_type engCtrl,
  input wire logic baudTick,
  // clock pin and requests
  input wire logic clkPinOe,
  input wire serial_ctrl_pkg::irq_req_type irqReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_q; // shadow of the control word
  logic [7:0] mode_q; // shadow of the mode word
  logic [6:0] gap_q; // cycles since the last tick
  logic clean_q; // a tick has passed since the last rate change
  // decode of writes and of the receive path
  wire ctlWr = regWrite && regAddr == serial_ctrl_pkg::OFS_CONTROL;
  wire rateWr = regWrite && (regAddr == serial_ctrl_pkg::OFS_MODE || regAddr == serial_ctrl_pkg::OFS_CARD);
  wire waitOn = ctl_q[3] && mode_q[2] && !mode_q[7];
  wire frameIn = engStat.rxFrameDone && ctl_q[4];
  wire hwClr = frameIn && waitOn && engStat.rxAddrBit;
  // shadows follow software writes; the address hit clears the wait bit
  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_q <= 8'h00;
      mode_q <= 8'h00;
    end else begin
      if (ctlWr) ctl_q <= regWrData;
      if (hwClr) ctl_q[3] <= 1'b0;
      if (regWrite && regAddr == serial_ctrl_pkg::OFS_MODE) mode_q <= regWrData;
    end
  end
  // tick spacing, trusted only after one tick at the new rate
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_q <= 7'h00;
      clean_q <= 1'b0;
    end else begin
      gap_q <= baudTick ? 7'h00 : gap_q + 7'h01;
      clean_q <= rateWr ? 1'b0 : (baudTick ? 1'b1 : clean_q);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_TX_EMPTY_IRQ: assert property (irqReq.txEmptyIrq == (engStat.txEmpty && ctl_q[7]))
    else $error("tx empty request disagrees with its enable");
  AST_RX_IRQ_GATE: assert property (!ctl_q[6] |-> !irqReq.rxFullIrq && !irqReq.rxFaultIrq)
    else $error("receive request passed while disabled");
  AST_TX_DONE_IRQ: assert property (irqReq.txDoneIrq == (engStat.txDone && ctl_q[2]))
    else $error("tx done request disagrees with its enable");
  AST_TX_ON: assert property (engCtrl.txOn == ctl_q[5])
    else $error("transmitter enable wrong");
  AST_RX_ON: assert property (engCtrl.rxOn == ctl_q[4] && (!engCtrl.rxStore || frameIn))
    else $error("receiver enable or store wrong");
  AST_SKIP: assert property (frameIn && waitOn && !engStat.rxAddrBit |-> !engCtrl.rxStore)
    else $error("data frame stored during address wait");
  AST_ADDR_HIT: assert property (hwClr |-> engCtrl.rxStore ##1 !ctl_q[3])
    else $error("address frame not accepted");
  AST_NO_WAIT: assert property (frameIn && !waitOn |-> engCtrl.rxStore)
    else $error("frame dropped outside address wait");
  AST_READ_CTL: assert property (regRead && regAddr == 3'h0 |=> regRdData == $past(ctl_q))
    else $error("control word read back wrong");
  AST_READ_PULSE: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside the answer cycle");
  AST_PIN_ASYNC: assert property (!mode_q[7] |-> clkPinOe == (ctl_q[1:0] == 2'b01) && engCtrl.extClkSel == ctl_q[1])
    else $error("clock pin function wrong");
  AST_BAUD_DIV: assert property (baudTick && clean_q && mode_q[1] |-> gap_q == (mode_q[0] ? 7'h3F : 7'h0F))
    else $error("baud source spacing wrong");
endmodule // serial_control_enables_asserts

bind serial_control_enables serial_control_enables_asserts chk_i (.clock, .reset, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .engStat, .engCtrl, .baudTick, .clkPinOe, .irqReq);

`default_nettype wire

// ### sim/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and register port
  logic clock, reset, regWrite, regRead, readPend_q;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData;
  // engine side, pin and requests
  serial_ctrl_pkg::engine_stat_type engStat;
  serial_ctrl_pkg::engine_ctrl_type engCtrl;
  serial_ctrl_pkg::irq_req_type irqReq;
  logic baudTick, clkPinIn, clkPinOut, clkPinOe, clkPinSync, eventIrq;
  // bookkeeping
  int nMismatch, checksDone, cycles;
  logic [31:0] seed;
  logic [7:0] expQ[$]; // expected read data, oldest first
  logic [7:0] gap;
  // short aliases of the register offsets
  localparam logic [2:0] CTL = serial_ctrl_pkg::OFS_CONTROL, MOD = serial_ctrl_pkg::OFS_MODE;
  localparam logic [2:0] FLG = serial_ctrl_pkg::OFS_FLAGS, EVT = serial_ctrl_pkg::OFS_EVENT;
  localparam logic [2:0] MSK = serial_ctrl_pkg::OFS_MASK;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  serial_control_enables serial_control_enables_i (.clock, .reset, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .engStat, .engCtrl, .baudTick, .clkPinIn, .clkPinOut, .clkPinOe, .clkPinSync, .irqReq, .eventIrq);
  engine_model engine_model_i (.clock, .engStat);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // one-cycle read strobe; the answer is noted for the monitor
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
  endtask
  // let edges pass, then settle past the edge
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // cycles between two baud ticks
  task automatic tick_gap(output logic [7:0] n);
    n = 8'h00;
    do @(posedge clock); while (!baudTick);
    do begin
      @(posedge clock);
      n++;
    end while (!baudTick && n < 8'hC8);
  endtask
  // monitor: answer of each read and the run limit
  always @(posedge clock) begin
    if (readPend_q) check("regRdData", regRdData, expQ.pop_front());
    readPend_q <= regRead;
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {regAddr, regWrData, regWrite, regRead, clkPinIn, readPend_q} = '0;
    {nMismatch, checksDone, cycles} = '0;
    seed = 32'd79958;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    // reset values, unmapped places included
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    // random control words against tx empty and tx done levels
    engine_model_i.levels(4'hC);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      clkPinIn <= seed[9];
      wr(CTL, seed[7:0]);
      rd(CTL, seed[7:0]);
      idle(1);
      check("txEmptyIrq", {7'h00, irqReq.txEmptyIrq}, {7'h00, seed[7]});
      check("txDoneIrq", {7'h00, irqReq.txDoneIrq}, {7'h00, seed[2]});
      check("engOn", {6'h00, engCtrl.txOn, engCtrl.rxOn}, {6'h00, seed[5:4]});
      check("clkPin", {5'h00, clkPinOe, clkPinOut, clkPinSync},
        {5'h00, seed[1:0] == 2'b01, seed[1:0] == 2'b01 && engStat.bitClk, seed[9]});
    end
    engine_model_i.levels(4'h0);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    // normal reception, overrun, framing, enable gating
    wr(CTL, 8'h50);
    engine_model_i.frame(1'b0, 1'b0, 1'b0);
    idle(1);
    check("rxFullIrq", {7'h00, irqReq.rxFullIrq}, 8'h01);
    engine_model_i.frame(1'b0, 1'b0, 1'b1);
    rd(FLG, 8'h60);
    idle(1);
    check("rxFaultIrq", {7'h00, irqReq.rxFaultIrq}, 8'h01);
    wr(CTL, 8'h10);
    idle(1);
    check("irqReq", {4'h0, irqReq}, 8'h00);
    wr(FLG, 8'h70);
    engine_model_i.frame(1'b0, 1'b1, 1'b0);
    rd(FLG, 8'h10);
    wr(FLG, 8'h70);
    wr(CTL, 8'h00);
    engine_model_i.frame(1'b0, 1'b0, 1'b0);
    rd(FLG, 8'h00);
    wr(EVT, 8'h0F);
    // address wait: data frame skipped, address frame ends the wait
    wr(MOD, 8'h04);
    wr(CTL, 8'h18);
    engine_model_i.frame(1'b0, 1'b0, 1'b0);
    rd(FLG, 8'h00);
    rd(CTL, 8'h18);
    engine_model_i.frame(1'b1, 1'b0, 1'b0);
    rd(CTL, 8'h10);
    rd(FLG, 8'h40);
    rd(EVT, 8'h07);
    // event interrupt: raise, mask, clear
    wr(MSK, 8'h04);
    idle(1);
    check("eventIrq", {7'h00, eventIrq}, 8'h01);
    wr(MSK, 8'h00);
    idle(1);
    check("eventIrq", {7'h00, eventIrq}, 8'h00);
    wr(MSK, 8'h04);
    wr(EVT, 8'h04);
    idle(1);
    check("eventIrq", {7'h00, eventIrq}, 8'h00);
    // wait bit ignored in clocked mode and without address format
    for (int m = 0; m < 2; m++) begin
      wr(FLG, 8'h70);
      wr(MOD, m ? 8'h00 : 8'h84);
      wr(CTL, 8'h18);
      engine_model_i.frame(1'b0, 1'b0, 1'b0);
      rd(CTL, 8'h18);
      rd(FLG, 8'h40);
    end
    // control write while the receiver shifts is still taken but flagged
    wr(EVT, 8'h0F);
    engine_model_i.levels(4'h1);
    wr(CTL, 8'h00);
    engine_model_i.levels(4'h0);
    rd(EVT, 8'h08);
    wr(MSK, 8'h08);
    idle(1);
    check("eventIrq", {7'h00, eventIrq}, 8'h01);
    // baud source in card mode, every code
    wr(serial_ctrl_pkg::OFS_CARD, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(MOD, 8'(s));
      tick_gap(gap);
      tick_gap(gap);
      check("baudGap", gap, 8'(1 << (2 * s)));
    end
    give_verdict();
  end
endmodule // tb

`default_nettype wire
